/* design/aoncr_pkg.sv */
// Purpose: shared constants of the analog output node configuration registers
// Assumes: one 10 MHz clock, synchronous active high reset
// Notes: addresses are holding register numbers as seen on the serial link
package aoncr_pkg;
   // holding register addresses
   localparam logic [15:0] ADR_IDENT = 16'h9c41;
   localparam logic [15:0] ADR_LINK = 16'h9c42;
   localparam logic [15:0] ADR_TMO = 16'h9c43;
   localparam logic [15:0] ADR_BEHAV = 16'h9c44;
   localparam logic [15:0] ADR_ERR = 16'h9c48;
   localparam logic [15:0] ADR_CMD = 16'h9c49;
   localparam logic [15:0] ADR_SNAP = 16'h9c4a;
   localparam logic [15:0] ADR_FW = 16'h9c4b;
   // reset values
   localparam logic [15:0] LINK_RST = 16'h0301;
   localparam logic [15:0] BEHAV_RST = 16'h0000;
   localparam logic [15:0] TMO_RST = 16'h0064;
   localparam logic [15:0] CMD_RST = 16'h0000;
   // writable bit masks, other bits read zero
   localparam logic [15:0] LINK_MASK = 16'h07ff;
   localparam logic [15:0] BEHAV_MASK = 16'h009c;
   // field positions
   localparam int BEH_FALLBACK_BIT = 7;
   localparam int BEH_PAR_ODD_BIT = 4;
   localparam int BEH_PAR_EN_BIT = 3;
   localparam int BEH_DELAY_BIT = 2;
   localparam int ERR_NVLOST_BIT = 4;
   localparam int ERR_FAULT_BIT = 2;
   localparam int SNAP_TYPE_LSB = 8;
   localparam int SNAP_BAUD_LSB = 6;
   // commands
   localparam logic [15:0] CMD_SAVE = 16'hbab0;
   localparam logic [15:0] CMD_SNAP = 16'hcac0;
   localparam logic [15:0] CMD_RESET = 16'hc1a0;
   // baud code of the lowest switch setting, 9600
   localparam logic [2:0] BAUD_SW_BASE = 3'h1;
   // identity, values arbitrary
   localparam logic [7:0] MODULE_TYPE_CODE = 8'h5a;
   localparam logic [7:0] EXT_REV = 8'h01;
   localparam logic [15:0] FIRMWARE_CODE = 16'h0100;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TENTH_NS = 100000000;
   localparam int TENTH_CYC = TENTH_NS / CLK_PERIOD_NS;
endpackage

/* design/aoncr_if.sv */
// Purpose: carrier between the register core, silence timer and settings store
// Assumes: all signals on ref_clk
// Notes: save is a one-cycle strobe
interface aoncr_if;
   logic activity;
   logic [15:0] tmo_tenths;
   logic fault;
   logic save;
   logic [15:0] save_link;
   logic [15:0] save_behav;
   logic [15:0] save_tmo;
   logic [15:0] img_link;
   logic [15:0] img_behav;
   logic [15:0] img_tmo;
   logic img_valid;
   modport core (output activity, tmo_tenths, save, save_link, save_behav, save_tmo,
                 input fault, img_link, img_behav, img_tmo, img_valid);
   modport timer (input activity, tmo_tenths, output fault);
   modport store (input save, save_link, save_behav, save_tmo,
                  output img_link, img_behav, img_tmo, img_valid);
endinterface

/* design/aoncr_silence_timer.sv */
// Purpose: measures bus silence in tenths of a second and raises the fault flag
// Assumes: activity pulses once per request addressed to this node
// Notes: tenths counter saturates so a long silence never wraps back to no fault
module aoncr_silence_timer #(
   parameter int TENTH_CYC = aoncr_pkg::TENTH_CYC
) (
   input logic ref_clk,
   input logic sys_rst,
   aoncr_if.timer lnk
);
   typedef struct packed {
      logic [31:0] pre;
      logic [15:0] tenths;
      logic fault;
   } aoncr_tmr_t;

   aoncr_tmr_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (lnk.activity) begin
         s_d.pre = '0;
         s_d.tenths = '0;
         s_d.fault = 1'b0;
      end else begin
         if (s_q.pre == 32'(TENTH_CYC - 1)) begin
            s_d.pre = '0;
            if (s_q.tenths != 16'hffff) begin
               s_d.tenths = s_q.tenths + 16'h0001;
            end
         end else begin
            s_d.pre = s_q.pre + 32'h0000_0001;
         end
         s_d.fault = (s_q.tenths > lnk.tmo_tenths);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lnk.fault = s_q.fault;

   AST_FAULT_CLEARS: assert property (@(posedge ref_clk) disable iff (sys_rst)
      lnk.activity |=> !lnk.fault)
      else $error("fault flag not cleared by bus activity");
endmodule

/* design/aoncr_settings_store.sv */
// Purpose: image of the saved link, behaviour and timeout settings
// Assumes: saved words arrive with a one-cycle save strobe
// Notes: power-on reset models a lost image; only a save makes it valid
module aoncr_settings_store (
   input logic ref_clk,
   input logic sys_rst,
   aoncr_if.store st
);
   typedef struct packed {
      logic [15:0] link;
      logic [15:0] behav;
      logic [15:0] tmo;
      logic valid;
   } aoncr_img_t;

   aoncr_img_t m_q, m_d;

   always_comb begin
      m_d = m_q;
      if (st.save) begin
         m_d.link = st.save_link;
         m_d.behav = st.save_behav;
         m_d.tmo = st.save_tmo;
         m_d.valid = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         m_q <= {aoncr_pkg::LINK_RST, aoncr_pkg::BEHAV_RST, aoncr_pkg::TMO_RST, 1'b0};
      end else begin
         m_q <= m_d;
      end
   end

   assign st.img_link = m_q.link;
   assign st.img_behav = m_q.behav;
   assign st.img_tmo = m_q.tmo;
   assign st.img_valid = m_q.valid;
endmodule

/* design/aoncr_regs.sv */
// Purpose: configuration, status and command holding registers of the output node
// Assumes: a framing layer presents decoded register reads and writes
// Notes: requests get no answer while the two-cycle settings reload runs
// Summary of operation
// - address from switches 3..8 (1..63); switches 1,2 choose 9600 to 57600 baud
// - all address switches off: address from link settings low byte, default 1
// - stored mode: baud code from link settings high byte, default 38400
// - error bit 4 shows lost stored settings; error register read only
// - error bit 2 set when silence exceeds timeout tenths, else zero
// - fault with behaviour bit 7 set: copy the three fallback outputs
// - behaviour bit 3 enables parity, bit 4 picks odd; both reset zero
// - parity sense only matters while parity enabled; same for both directions
// - behaviour bit 2 inserts a pause before each reply
// - command 0xbab0 saves configuration; command register resets to zero
// - command 0xcac0 captures the switch bank into the snapshot register
// - command 0xc1a0 performs a module reset
// - snapshot bit 10 is channel three type, one means voltage; 15..11 zero
// - snapshot bits 9,8 types, 7:6 baud switches, 5:0 address switches
module aoncr_regs #(
   parameter int TENTH_CYC = aoncr_pkg::TENTH_CYC
) (
   input logic ref_clk,
   input logic sys_rst,
   input logic [15:0] reg_addr,
   input logic reg_wr,
   input logic reg_rd,
   input logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_err,
   input logic [1:0] dip_baud,
   input logic [5:0] dip_addr,
   input logic [2:0] dip_type_on,
   input logic bus_activity,
   output logic [7:0] node_addr,
   output logic [2:0] baud_code,
   output logic parity_en,
   output logic parity_odd,
   output logic reply_delay_en,
   output logic fallback_copy,
   output logic config_ready
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_APPLY = 2'b10
   } aoncr_st_t;

   typedef struct packed {
      aoncr_st_t st;
      logic [15:0] link;
      logic [15:0] behav;
      logic [15:0] tmo;
      logic [15:0] cmd;
      logic [15:0] snap;
      logic [7:0] node;
      logic [2:0] baud;
      logic [15:0] rdata;
      logic ack;
      logic err;
      logic save;
      logic fb;
      logic fault_prev;
   } aoncr_core_t;

   aoncr_core_t r_q, r_d;
   aoncr_if lnk ();

   logic take;
   logic [15:0] err_word;
   logic [15:0] snap_now;

   aoncr_silence_timer #(.TENTH_CYC(TENTH_CYC)) u_timer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .lnk(lnk.timer)
   );

   aoncr_settings_store u_store (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .st(lnk.store)
   );

   assign lnk.activity = bus_activity;
   assign lnk.tmo_tenths = r_q.tmo;
   assign lnk.save = r_q.save;
   assign lnk.save_link = r_q.link;
   assign lnk.save_behav = r_q.behav;
   assign lnk.save_tmo = r_q.tmo;

   // no request is taken while settings are being reloaded
   assign take = (reg_wr | reg_rd) && (r_q.st == ST_IDLE);

   always_comb begin
      err_word = '0;
      err_word[aoncr_pkg::ERR_NVLOST_BIT] = ~lnk.img_valid;
      err_word[aoncr_pkg::ERR_FAULT_BIT] = lnk.fault;
   end

   // switch on means current output, register bit one means voltage
   assign snap_now = {5'h00, ~dip_type_on, dip_baud, dip_addr};

   always_comb begin
      r_d = r_q;
      r_d.ack = 1'b0;
      r_d.err = 1'b0;
      r_d.save = 1'b0;
      r_d.fault_prev = lnk.fault;
      // only the rising edge of the fault copies, so outputs stay writable afterwards
      r_d.fb = lnk.fault && !r_q.fault_prev && r_q.behav[aoncr_pkg::BEH_FALLBACK_BIT];
      case (r_q.st)
         ST_IDLE: begin
            if (take) begin
               r_d.ack = 1'b1;
               r_d.rdata = '0;
               if (reg_rd) begin
                  case (reg_addr)
                     aoncr_pkg::ADR_IDENT: r_d.rdata = {aoncr_pkg::MODULE_TYPE_CODE, aoncr_pkg::EXT_REV};
                     aoncr_pkg::ADR_LINK: r_d.rdata = r_q.link;
                     aoncr_pkg::ADR_TMO: r_d.rdata = r_q.tmo;
                     aoncr_pkg::ADR_BEHAV: r_d.rdata = r_q.behav;
                     aoncr_pkg::ADR_ERR: r_d.rdata = err_word;
                     aoncr_pkg::ADR_CMD: r_d.rdata = r_q.cmd;
                     aoncr_pkg::ADR_SNAP: r_d.rdata = r_q.snap;
                     aoncr_pkg::ADR_FW: r_d.rdata = aoncr_pkg::FIRMWARE_CODE;
                     default: r_d.err = 1'b1;
                  endcase
               end else begin
                  case (reg_addr)
                     aoncr_pkg::ADR_LINK: r_d.link = reg_wdata & aoncr_pkg::LINK_MASK;
                     aoncr_pkg::ADR_TMO: r_d.tmo = reg_wdata;
                     aoncr_pkg::ADR_BEHAV: r_d.behav = reg_wdata & aoncr_pkg::BEHAV_MASK;
                     aoncr_pkg::ADR_CMD: begin
                        r_d.cmd = reg_wdata;
                        case (reg_wdata)
                           aoncr_pkg::CMD_SAVE: r_d.save = 1'b1;
                           aoncr_pkg::CMD_SNAP: r_d.snap = snap_now;
                           aoncr_pkg::CMD_RESET: r_d.st = ST_LOAD;
                           default: r_d.save = 1'b0;
                        endcase
                     end
                     // read-only and unmapped words are left untouched
                     default: r_d.err = 1'b1;
                  endcase
               end
            end
         end
         ST_LOAD: begin
            // module reset: settings return to the saved image only if it is valid, else keep their values; command clears
            if (lnk.img_valid) begin
               r_d.link = lnk.img_link & aoncr_pkg::LINK_MASK;
               r_d.behav = lnk.img_behav & aoncr_pkg::BEHAV_MASK;
               r_d.tmo = lnk.img_tmo;
            end
            r_d.cmd = aoncr_pkg::CMD_RST;
            r_d.st = ST_APPLY;
         end
         ST_APPLY: begin
            if (dip_addr != 6'h00) begin
               r_d.node = {2'b00, dip_addr};
               r_d.baud = aoncr_pkg::BAUD_SW_BASE + {1'b0, dip_baud};
            end else begin
               r_d.node = r_q.link[7:0];
               r_d.baud = r_q.link[10:8];
            end
            r_d.st = ST_IDLE;
         end
         default: r_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         // power-on goes through the same reload as the reset command
         r_q <= '0;
         r_q.st <= ST_LOAD;
         r_q.link <= aoncr_pkg::LINK_RST;
         r_q.behav <= aoncr_pkg::BEHAV_RST;
         r_q.tmo <= aoncr_pkg::TMO_RST;
         r_q.cmd <= aoncr_pkg::CMD_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign reg_rdata = r_q.rdata;
   assign reg_ack = r_q.ack;
   assign reg_err = r_q.err;
   assign node_addr = r_q.node;
   assign baud_code = r_q.baud;
   assign parity_en = r_q.behav[aoncr_pkg::BEH_PAR_EN_BIT];
   // sense is forced even-coded off while parity is disabled
   assign parity_odd = r_q.behav[aoncr_pkg::BEH_PAR_EN_BIT] & r_q.behav[aoncr_pkg::BEH_PAR_ODD_BIT];
   assign reply_delay_en = r_q.behav[aoncr_pkg::BEH_DELAY_BIT];
   assign fallback_copy = r_q.fb;
   assign config_ready = (r_q.st == ST_IDLE);

   // request decodes shared by the checks below
   logic chk_wr_cmd;
   logic chk_rd_err;
   logic chk_wr_behav;
   logic chk_mapped;

   assign chk_wr_cmd = take && reg_wr && (reg_addr == aoncr_pkg::ADR_CMD);
   assign chk_rd_err = take && reg_rd && (reg_addr == aoncr_pkg::ADR_ERR);
   assign chk_wr_behav = take && reg_wr && (reg_addr == aoncr_pkg::ADR_BEHAV);
   assign chk_mapped = reg_addr inside {aoncr_pkg::ADR_IDENT, aoncr_pkg::ADR_LINK, aoncr_pkg::ADR_TMO,
      aoncr_pkg::ADR_BEHAV, aoncr_pkg::ADR_ERR, aoncr_pkg::ADR_CMD, aoncr_pkg::ADR_SNAP, aoncr_pkg::ADR_FW};

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // address and baud selection, only checked at the reload edge
   AST_ADDR_FROM_SWITCH: assert property (
      (r_q.st == ST_APPLY && dip_addr != 6'h00) |=>
         node_addr == {2'b00, $past(dip_addr)} && baud_code == aoncr_pkg::BAUD_SW_BASE + {1'b0, $past(dip_baud)})
      else $error("switch address or baud not applied");
   AST_ADDR_FROM_STORE: assert property (
      (r_q.st == ST_APPLY && dip_addr == 6'h00) |=> node_addr == $past(r_q.link[7:0]))
      else $error("stored address not applied");
   AST_BAUD_FROM_STORE: assert property (
      (r_q.st == ST_APPLY && dip_addr == 6'h00) |=> baud_code == $past(r_q.link[10:8]))
      else $error("stored baud code not applied");

   // status word
   AST_ERR_NVLOST: assert property (
      chk_rd_err |=> reg_rdata[aoncr_pkg::ERR_NVLOST_BIT] == !$past(lnk.img_valid) && reg_rdata[3] == 1'b0)
      else $error("error bit 4 does not show stored data loss");
   AST_ERR_FAULT: assert property (
      chk_rd_err |=> reg_rdata[aoncr_pkg::ERR_FAULT_BIT] == $past(lnk.fault))
      else $error("error bit 2 does not follow the fault flag");
   AST_ERR_UNUSED_ZERO: assert property (
      chk_rd_err |=> reg_rdata[15:5] == 11'h000 && reg_rdata[1:0] == 2'h0)
      else $error("unused error bits not zero");

   // fallback copy
   AST_FALLBACK: assert property (
      ($rose(lnk.fault) && r_q.behav[aoncr_pkg::BEH_FALLBACK_BIT]) |=> fallback_copy ##1 !fallback_copy)
      else $error("fallback copy not issued once on fault");
   AST_NO_FALLBACK: assert property (
      !r_q.behav[aoncr_pkg::BEH_FALLBACK_BIT] |=> !fallback_copy)
      else $error("fallback copy issued while disabled");
   AST_FALLBACK_NEEDS_FAULT: assert property (
      fallback_copy |-> $past(lnk.fault))
      else $error("fallback copy issued without a fault");

   // behaviour bits
   AST_PARITY_FROM_WRITE: assert property (
      chk_wr_behav |=> parity_en == $past(reg_wdata[aoncr_pkg::BEH_PAR_EN_BIT])
         && parity_odd == ($past(reg_wdata[aoncr_pkg::BEH_PAR_EN_BIT]) && $past(reg_wdata[aoncr_pkg::BEH_PAR_ODD_BIT])))
      else $error("parity settings not taken from behaviour write");
   AST_PARITY_SENSE: assert property (
      parity_odd |-> parity_en)
      else $error("odd parity reported while parity disabled");
   AST_DELAY_FROM_WRITE: assert property (
      chk_wr_behav |=> reply_delay_en == $past(reg_wdata[aoncr_pkg::BEH_DELAY_BIT]))
      else $error("reply pause not taken from behaviour write");

   // commands
   AST_SAVE: assert property (
      (chk_wr_cmd && reg_wdata == aoncr_pkg::CMD_SAVE) |=> lnk.save ##1 lnk.img_valid)
      else $error("save command did not store settings");
   AST_SAVE_CONTENT: assert property (
      lnk.save |=> lnk.img_link == $past(r_q.link) && lnk.img_behav == $past(r_q.behav))
      else $error("saved image differs from the configuration");
   AST_CMD_HELD: assert property (
      chk_wr_cmd |=> r_q.cmd == $past(reg_wdata))
      else $error("command word not stored");
   AST_SNAPSHOT: assert property (
      (chk_wr_cmd && reg_wdata == aoncr_pkg::CMD_SNAP) |=>
         r_q.snap[5:0] == $past(dip_addr) && r_q.snap[10] == !$past(dip_type_on[2]) && r_q.snap[15:11] == 5'h00)
      else $error("switch snapshot wrong");
   AST_SNAP_FIELDS: assert property (
      (chk_wr_cmd && reg_wdata == aoncr_pkg::CMD_SNAP) |=>
         r_q.snap[9:8] == ~$past(dip_type_on[1:0]) && r_q.snap[7:6] == $past(dip_baud))
      else $error("snapshot type or baud fields wrong");
   AST_RESET_RELOAD: assert property (
      (chk_wr_cmd && reg_wdata == aoncr_pkg::CMD_RESET) |=>
         !config_ready ##1 !config_ready ##1 (config_ready && r_q.cmd == aoncr_pkg::CMD_RST))
      else $error("reset command reload sequence wrong");

   // refused accesses and answer timing
   AST_RO_REFUSED: assert property (
      (take && reg_wr && reg_addr == aoncr_pkg::ADR_ERR) |=> reg_err && reg_ack)
      else $error("write to read-only register not flagged");
   AST_SNAP_RO: assert property (
      (take && reg_wr && reg_addr == aoncr_pkg::ADR_SNAP) |=> $stable(r_q.snap))
      else $error("write changed the snapshot register");
   AST_UNMAPPED_READ: assert property (
      (take && reg_rd && !chk_mapped) |=> reg_err && reg_rdata == 16'h0000)
      else $error("unmapped read not refused");
   AST_LINK_MASK: assert property (
      (take && reg_wr && reg_addr == aoncr_pkg::ADR_LINK) |=> r_q.link[15:11] == 5'h00)
      else $error("unused link bits stored");
   AST_ERR_NEEDS_ACK: assert property (
      reg_err |-> reg_ack)
      else $error("error flag without an answer");
   AST_BUSY_NO_ACK: assert property (
      (r_q.st != ST_IDLE) |=> !reg_ack)
      else $error("request answered during reload");
   AST_NO_ACK_IDLE: assert property (
      !take |=> !reg_ack)
      else $error("answer without a taken request");

   COV_SAVE: cover property (chk_wr_cmd && reg_wdata == aoncr_pkg::CMD_SAVE);
   COV_FALLBACK: cover property (fallback_copy);
   COV_RESET: cover property ((r_q.st == ST_APPLY) ##1 config_ready ##[1:8] reg_ack);
   COV_SNAPSHOT: cover property (chk_wr_cmd && reg_wdata == aoncr_pkg::CMD_SNAP);
   COV_STORED_RELOAD: cover property (r_q.st == ST_APPLY && lnk.img_valid && dip_addr == 6'h00);
endmodule

/* tb/aoncr_master_model.sv */
// Purpose: link master stand-in that issues decoded register requests
// Assumes: requests are one-cycle pulses driven on the falling edge
// Notes: idle address and data are inverted so stale values never pass
module aoncr_master_model (
   input wire logic ref_clk,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // a held strobe would be a second request, so it is a single pulse
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] r, output logic e, output logic ok);
      ok = 1'b0;
      r = 16'h0000;
      e = 1'b0;
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
         if (reg_ack === 1'b1) begin
            ok = 1'b1;
            r = reg_rdata;
            e = reg_err;
         end else begin
            @(negedge ref_clk);
         end
      end
   endtask
endmodule

/* tb/aoncr_regs_tb_top.sv */
// Purpose: self-checking bench of the output node configuration registers
// Assumes: a tenth of a second shortened to a few cycles
// Notes: bus activity is pulsed by hand so silence length is known
module aoncr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 4;
   // lowest timeout the master may program, in tenths
   localparam int TMO = 10;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic reg_wr, reg_rd, reg_ack, reg_err, ev, ok;
   logic bus_activity = 1'b0;
   logic [1:0] dip_baud = 2'h0;
   logic [5:0] dip_addr = 6'h00;
   logic [2:0] dip_type_on = 3'h0;
   logic [7:0] node_addr;
   logic [2:0] baud_code;
   logic parity_en, parity_odd, reply_delay_en, fallback_copy, config_ready;
   logic [15:0] ro[4];
   logic [15:0] bv[4];
   logic [2:0] bx[4];
   int err_count = 0;
   int cmp_count = 0;
   int fb_count = 0;
   int n;
   always #50 ref_clk = ~ref_clk;
   always @(negedge ref_clk) if (fallback_copy === 1'b1) fb_count++;
   aoncr_regs #(.TENTH_CYC(TC)) i_aoncr_regs (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err), .dip_baud(dip_baud),
      .dip_addr(dip_addr), .dip_type_on(dip_type_on), .bus_activity(bus_activity),
      .node_addr(node_addr), .baud_code(baud_code), .parity_en(parity_en),
      .parity_odd(parity_odd), .reply_delay_en(reply_delay_en),
      .fallback_copy(fallback_copy), .config_ready(config_ready));
   aoncr_master_model i_aoncr_master_model (.ref_clk(ref_clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_err(reg_err));
   task automatic give_verdict();
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e);
      i_aoncr_master_model.xfer(w, a, d, rv, ev, ok);
      chk("reg_ack", {15'h0000, ok}, 16'h0001);
      if (ok !== 1'b1) give_verdict();
      chk($sformatf("reg_err at %h", a), {15'h0000, ev}, {15'h0000, e});
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
      acc(1'b1, a, d, e);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic e);
      acc(1'b0, a, 16'h0000, e);
      chk($sformatf("reg_rdata at %h", a), rv, x);
   endtask
   // bounded, a reload that never ends closes the run
   task automatic wait_ready();
      for (n = 0; n < 10 && config_ready !== 1'b1; n++) @(negedge ref_clk);
      chk("config_ready", {15'h0000, config_ready}, 16'h0001);
      if (config_ready !== 1'b1) give_verdict();
   endtask
   task automatic mod_reset();
      wr(aoncr_pkg::ADR_CMD, aoncr_pkg::CMD_RESET, 1'b0);
      chk("config_ready", {15'h0000, config_ready}, 16'h0000);
      wait_ready();
   endtask
   task automatic poke();
      bus_activity = 1'b1;
      @(negedge ref_clk);
      bus_activity = 1'b0;
   endtask
   initial begin
      ro = '{aoncr_pkg::ADR_ERR, aoncr_pkg::ADR_SNAP, aoncr_pkg::ADR_FW, 16'h9c45};
      bv = '{16'hffff, 16'h0010, 16'h0008, 16'h0000};
      bx = '{3'h7, 3'h0, 3'h4, 3'h0};
      repeat (5) @(negedge ref_clk);
      sys_rst = 1'b0;
      wait_ready();
      chk("node_addr", {8'h00, node_addr}, 16'h0001);
      chk("baud_code", {13'h0000, baud_code}, 16'h0003);
      rd(aoncr_pkg::ADR_LINK, 16'h0301, 1'b0);
      rd(aoncr_pkg::ADR_ERR, 16'h0010, 1'b0);
      rd(aoncr_pkg::ADR_CMD, 16'h0000, 1'b0);
      rd(aoncr_pkg::ADR_TMO, 16'h0064, 1'b0);
      foreach (bv[i]) begin
         wr(aoncr_pkg::ADR_BEHAV, bv[i], 1'b0);
         rd(aoncr_pkg::ADR_BEHAV, bv[i] & 16'h009c, 1'b0);
         chk("parity and delay", {13'h0000, parity_en, parity_odd, reply_delay_en}, {13'h0000, bx[i]});
      end
      foreach (ro[i]) wr(ro[i], 16'hffff, 1'b1);
      wr(aoncr_pkg::ADR_IDENT, 16'hffff, 1'b1);
      rd(16'h9c45, 16'h0000, 1'b1);
      rd(aoncr_pkg::ADR_ERR, 16'h0010, 1'b0);
      rd(aoncr_pkg::ADR_IDENT, {aoncr_pkg::MODULE_TYPE_CODE, aoncr_pkg::EXT_REV}, 1'b0);
      rd(aoncr_pkg::ADR_FW, aoncr_pkg::FIRMWARE_CODE, 1'b0);
      wr(aoncr_pkg::ADR_LINK, 16'hff12, 1'b0);
      rd(aoncr_pkg::ADR_LINK, 16'h0712, 1'b0);
      wr(aoncr_pkg::ADR_LINK, 16'h0512, 1'b0);
      wr(aoncr_pkg::ADR_CMD, aoncr_pkg::CMD_SAVE, 1'b0);
      rd(aoncr_pkg::ADR_ERR, 16'h0000, 1'b0);
      mod_reset();
      chk("node_addr", {8'h00, node_addr}, 16'h0012);
      chk("baud_code", {13'h0000, baud_code}, 16'h0005);
      rd(aoncr_pkg::ADR_CMD, 16'h0000, 1'b0);
      rd(aoncr_pkg::ADR_LINK, 16'h0512, 1'b0);
      // top address down to 60 keeps every switch code on a boundary-ish value
      for (int b = 0; b < 4; b++) begin
         dip_baud = b[1:0];
         dip_addr = 6'h3f - b[5:0];
         mod_reset();
         chk("node_addr", {8'h00, node_addr}, {10'h000, dip_addr});
         chk("baud_code", {13'h0000, baud_code}, 16'(b + 1));
      end
      dip_type_on = 3'h1;
      dip_baud = 2'h2;
      dip_addr = 6'h15;
      wr(aoncr_pkg::ADR_CMD, aoncr_pkg::CMD_SNAP, 1'b0);
      dip_type_on = 3'h6;
      dip_addr = 6'h2a;
      rd(aoncr_pkg::ADR_SNAP, {5'h00, 3'h6, 2'h2, 6'h15}, 1'b0);
      wr(aoncr_pkg::ADR_TMO, 16'(TMO), 1'b0);
      wr(aoncr_pkg::ADR_BEHAV, 16'h0080, 1'b0);
      poke();
      for (n = 1; n < 80 && fallback_copy !== 1'b1; n++) @(negedge ref_clk);
      chk("silence cycles", {15'h0000, n > TMO * TC && n <= (TMO + 1) * TC + 4}, 16'h0001);
      rd(aoncr_pkg::ADR_ERR, 16'h0004, 1'b0);
      chk("fallback pulses", 16'(fb_count), 16'h0001);
      poke();
      rd(aoncr_pkg::ADR_ERR, 16'h0000, 1'b0);
      wr(aoncr_pkg::ADR_BEHAV, 16'h0000, 1'b0);
      poke();
      repeat (60) @(negedge ref_clk);
      rd(aoncr_pkg::ADR_ERR, 16'h0004, 1'b0);
      chk("fallback pulses", 16'(fb_count), 16'h0001);
      give_verdict();
   end
endmodule
